// *** shared/udt_pkg.sv ***
package udt_pkg;

  // ******************************************************************
  // counting and timing constants
  // ******************************************************************
  localparam int          DIV_RATIO = 12;      // internal clock divide
  localparam logic [15:0] CNT_TOP   = 16'hffff; // up-count wrap point
  localparam logic [7:0]  BYTE_TOP  = 8'hff;   // low byte carry point
  localparam logic [7:0]  BYTE_LOW  = 8'h00;   // low byte borrow point

  // ******************************************************************
  // register indices (byte address is four times the index)
  // ******************************************************************
  localparam logic [7:0] IDX_CTRL   = 8'hc8;   // timer_control_register
  localparam logic [7:0] IDX_MODE   = 8'hc9;   // timer_mode_register
  localparam logic [7:0] IDX_CNT_LO = 8'hca;   // count_low_byte
  localparam logic [7:0] IDX_CNT_HI = 8'hcb;   // count_high_byte
  localparam logic [7:0] IDX_RLD_LO = 8'hcc;   // reload_low_byte
  localparam logic [7:0] IDX_RLD_HI = 8'hcd;   // reload_high_byte
  localparam logic [7:0] IDX_IRQ_EN = 8'hce;   // interrupt enable
  localparam logic [7:0] IDX_STATUS = 8'hcf;   // live status

  // ******************************************************************
  // field positions and reset values
  // ******************************************************************
  localparam int         MODE_DOWN_COUNT_ENABLE_BIT   = 0;  // down_count_enable
  localparam int         MODE_CLKOUT_BIT = 1; // stored only
  localparam int         IRQ_EN_BIT      = 0;  // timer interrupt enable
  localparam int         ST_DIR_BIT      = 0;  // direction_pin level
  localparam int         ST_UPDN_BIT     = 1;  // up/down mode active
  localparam int         ST_MODE_LSB     = 2;  // two-bit mode code
  localparam int         ST_IRQ_BIT      = 4;  // irq output level
  localparam logic [7:0] CTRL_RST        = 8'h00;
  localparam logic [1:0] MODE_RST        = 2'h0;
  localparam logic [7:0] BYTE_RST        = 8'h00;
  localparam logic       IRQ_EN_RST      = 1'b0;

  // ******************************************************************
  // types
  // ******************************************************************
  typedef struct packed {
    logic ovf;    // overflow_flag
    logic ext;    // external_flag
    logic rclk;   // receive clock select
    logic transmit_clock_select;   // transmit_clock_select
    logic exen;   // direction pin event enable
    logic run;    // run_control_bit
    logic ct;     // timer_counter_select
    logic cprl;   // capture_reload_select
  } udt_ctrl_type;

  typedef struct packed {
    logic       wr;   // write data phase pending
    logic [7:0] idx;  // register index
  } udt_addr_type;

  typedef enum logic [1:0] {UDT_CAPTURE, UDT_RELOAD, UDT_BAUD}
    udt_mode_type;

  typedef enum logic {PH_IDLE, PH_RWAIT} udt_phase_type;

endpackage

// *** logic/udt_tick_div.sv ***
`timescale 1ns/1ns
module udt_tick_div import udt_pkg::*; #(
  parameter int DIV = DIV_RATIO            // divide ratio
) (
  input  wire logic hclk,                  // clock
  input  wire logic hresetn,               // async reset, low
  input  wire logic ce,                    // clock enable
  input  wire logic run,                   // counting allowed
  output logic      tick                   // one pulse per DIV
);
  localparam int          CW   = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] div_q;                    // cycle counter

  // divider restarts whenever the timer is stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= '0;
    end else if (ce) begin
      if (!run || div_q == LAST) begin
        div_q <= '0;
      end else begin
        div_q <= div_q + CW'(1);
      end
    end
  end

  assign tick = ce & run & (div_q == LAST); // RULE2

  chk_tick_last: assert property ( // RULE2
    @(posedge hclk) disable iff (!hresetn)
    tick |=> (div_q == '0))
    else $error("divider did not restart after tick");

endmodule // udt_tick_div

// *** logic/udt_fall_det.sv ***
`timescale 1ns/1ns
module udt_fall_det (
  input  wire logic hclk,                  // clock
  input  wire logic hresetn,               // async reset, low
  input  wire logic ce,                    // clock enable
  input  wire logic pin,                   // synchronous pin level
  output logic      fall                   // falling edge pulse
);
  logic prev_q;                            // pin level last cycle

  // remember the pin, idle high so reset makes no edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b1;
    end else if (ce) begin
      prev_q <= pin;
    end
  end

  assign fall = ce & prev_q & ~pin;        // RULE16

  chk_fall_edge: assert property ( // RULE16
    @(posedge hclk) disable iff (!hresetn)
    (ce && $past(ce) && $fell(pin)) |-> fall)
    else $error("falling edge on pin was missed");

endmodule // udt_fall_det

// *** logic/udt_timer.sv ***
// Summary of operation
// RULE1 - 16-bit count held as low and high byte; low carry bumps high
// RULE2 - clock source: clock divided by 12, or count pin when selected
// RULE3 - count events only while run bit set; otherwise count holds
// RULE4 - three modes: capture, auto-reload, baud, from clock/select bits
// RULE5 - down-count enable in auto-reload gives up/down counting
// RULE6 - up/down mode counts up while direction pin high
// RULE7 - up count passing FFFFh sets overflow flag, requests interrupt
// RULE8 - up-count overflow loads reload bytes into count bytes; in capture mode the count wraps to 0000h instead
// RULE9 - up/down mode counts down while direction pin low
// RULE10 - down count reaching reload value is an underflow
// RULE11 - underflow sets overflow flag and loads FFFFh
// RULE12 - up/down mode toggles external flag on each wrap
// RULE13 - toggling external flag never requests interrupt
// RULE14 - external flag readable as seventeenth count bit; code reads it only as bit 6 of the control register
// RULE15 - overflow flag set only without serial clock select; sw clears
// RULE16 - counter operation counts falling edges of count pin
// RULE17 - serial clock select forces auto-reload, ignores select bit
// RULE18 - without down-count enable, reload mode counts up only
// RULE19 - irq high while overflow flag set and interrupt enabled
`timescale 1ns/1ns
module udt_timer import udt_pkg::*; #(
  parameter int DIV = DIV_RATIO            // internal clock divide
) (
  input  wire logic        hclk,           // bus clock, 10 MHz
  input  wire logic        hresetn,        // async reset, low
  input  wire logic        ce,             // clock enable
  input  wire logic        hsel,           // slave select
  input  wire logic [31:0] haddr,          // byte address
  input  wire logic [1:0]  htrans,         // transfer type
  input  wire logic        hwrite,         // write when high
  input  wire logic [2:0]  hsize,          // transfer size
  input  wire logic [31:0] hwdata,         // write data
  input  wire logic        hready,         // bus ready in
  output logic             hreadyout,      // slave ready out
  output logic [31:0]      hrdata,         // read data
  output logic             hresp,          // always okay
  input  wire logic        count_input_pin, // external count input
  input  wire logic        direction_pin,  // count direction
  output logic             irq             // interrupt request
);

  // ******************************************************************
  // state
  // ******************************************************************
  udt_ctrl_type  ctrl_q;                   // control and flags
  logic [1:0]    mode_q;                   // mode register bits
  logic [7:0]    count_low_byte_q;         // count bits 7:0
  logic [7:0]    count_high_byte_q;        // count bits 15:8
  logic [7:0]    reload_low_byte_q;        // reload bits 7:0
  logic [7:0]    reload_high_byte_q;       // reload bits 15:8
  logic          irq_en_q;                 // interrupt enable
  udt_addr_type  aph_q;                    // captured address phase
  udt_phase_type ph_q;                     // read wait tracking
  logic [7:0]    rd_idx_q;                 // index of pending read
  logic [31:0]   hrdata_q;                 // read data register

  udt_ctrl_type  ctrl_d;                   // next control value
  logic [7:0]    count_low_byte_d, count_high_byte_d; // next count bytes
  logic [31:0]   rd_mux;                   // read data select
  logic [15:0]   count, reload;            // joined byte pairs
  logic          pre_tick, pin_fall, dir_fall, src_ev, cnt_ev; // events
  udt_mode_type  mode;                     // decoded mode
  logic          serial, updown, up, wrap_up, wrap_dn, pin_trig;
  logic          req, in_map;              // bus request decode

  // ******************************************************************
  // input event sources
  // ******************************************************************
  udt_tick_div #(.DIV(DIV)) u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .run     (ctrl_q.run),
    .tick    (pre_tick)
  );

  udt_fall_det u_cnt_pin (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .pin     (count_input_pin),
    .fall    (pin_fall)
  );

  udt_fall_det u_dir_pin (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .pin     (direction_pin),
    .fall    (dir_fall)
  );

  // ******************************************************************
  // mode decode and count events
  // ******************************************************************
  assign src_ev = ctrl_q.ct ? pin_fall : pre_tick;      // RULE2
  assign cnt_ev = ce & ctrl_q.run & src_ev;             // RULE3
  assign serial = ctrl_q.rclk | ctrl_q.transmit_clock_select;
  assign count  = {count_high_byte_q, count_low_byte_q};
  assign reload = {reload_high_byte_q, reload_low_byte_q};

  // serial select overrides capture select
  always_comb begin
    if (serial) begin
      mode = UDT_BAUD;                                  // RULE17
    end else if (ctrl_q.cprl) begin
      mode = UDT_CAPTURE;                               // RULE4
    end else begin
      mode = UDT_RELOAD;
    end
  end

  assign updown   = (mode == UDT_RELOAD) & mode_q[MODE_DOWN_COUNT_ENABLE_BIT]; // RULE5
  assign up       = ~updown | direction_pin;      // RULE6 RULE9 RULE18
  assign wrap_up  = cnt_ev & up & (count == CNT_TOP);   // RULE7
  assign wrap_dn  = cnt_ev & ~up & (count == reload);   // RULE10
  assign pin_trig = ce & ctrl_q.exen & dir_fall & ~serial & ~updown;

  // ******************************************************************
  // cascaded count bytes
  // ******************************************************************
  always_comb begin
    count_low_byte_d  = count_low_byte_q;
    count_high_byte_d = count_high_byte_q;
    if (wrap_dn) begin
      {count_high_byte_d, count_low_byte_d} = CNT_TOP;  // RULE11
    end else if (wrap_up && mode != UDT_CAPTURE) begin
      {count_high_byte_d, count_low_byte_d} = reload;   // RULE8 RULE17
    end else if (pin_trig && mode == UDT_RELOAD) begin
      {count_high_byte_d, count_low_byte_d} = reload;
    end else if (cnt_ev && up) begin
      count_low_byte_d = count_low_byte_q + 8'h01;      // RULE1
      if (count_low_byte_q == BYTE_TOP) begin
        count_high_byte_d = count_high_byte_q + 8'h01;  // RULE1
      end
    end else if (cnt_ev) begin
      count_low_byte_d = count_low_byte_q - 8'h01;      // RULE9
      if (count_low_byte_q == BYTE_LOW) begin
        count_high_byte_d = count_high_byte_q - 8'h01;
      end
    end
    // software write to a count byte overrides counting
    if (aph_q.wr && aph_q.idx == IDX_CNT_LO) begin
      count_low_byte_d = hwdata[7:0];
    end
    if (aph_q.wr && aph_q.idx == IDX_CNT_HI) begin
      count_high_byte_d = hwdata[7:0];
    end
  end

  // count registers, frozen while ce is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_low_byte_q  <= BYTE_RST;
      count_high_byte_q <= BYTE_RST;
    end else if (ce) begin
      count_low_byte_q  <= count_low_byte_d;
      count_high_byte_q <= count_high_byte_d;
    end
  end

  // reload bytes: software writes, capture from direction pin edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_low_byte_q  <= BYTE_RST;
      reload_high_byte_q <= BYTE_RST;
    end else if (ce) begin
      if (pin_trig && mode == UDT_CAPTURE) begin
        {reload_high_byte_q, reload_low_byte_q} <= count;
      end
      if (aph_q.wr && aph_q.idx == IDX_RLD_LO) begin
        reload_low_byte_q <= hwdata[7:0];
      end
      if (aph_q.wr && aph_q.idx == IDX_RLD_HI) begin
        reload_high_byte_q <= hwdata[7:0];
      end
    end
  end

  // ******************************************************************
  // control register and flags; hardware set beats software clear
  // ******************************************************************
  always_comb begin
    ctrl_d = ctrl_q;
    if (aph_q.wr && aph_q.idx == IDX_CTRL) begin
      ctrl_d = udt_ctrl_type'(hwdata[7:0]);             // RULE15
    end
    if ((wrap_up || wrap_dn) && !serial) begin
      ctrl_d.ovf = 1'b1;                                // RULE7 RULE11 RULE15
    end
    if ((wrap_up || wrap_dn) && updown) begin
      ctrl_d.ext = ~ctrl_d.ext;                         // RULE12
    end
    if (pin_trig) begin
      ctrl_d.ext = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= udt_ctrl_type'(CTRL_RST);
    end else if (ce) begin
      ctrl_q <= ctrl_d;
    end
  end

  // mode and interrupt enable registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q   <= MODE_RST;
      irq_en_q <= IRQ_EN_RST;
    end else if (ce) begin
      if (aph_q.wr && aph_q.idx == IDX_MODE) begin
        mode_q <= hwdata[1:0];
      end
      if (aph_q.wr && aph_q.idx == IDX_IRQ_EN) begin
        irq_en_q <= hwdata[IRQ_EN_BIT];
      end
    end
  end

  // external flag requests only outside up/down mode
  assign irq = irq_en_q & (ctrl_q.ovf | (ctrl_q.ext & ~updown)); // RULE13 RULE19

  // ******************************************************************
  // ahb-lite slave
  // ******************************************************************
  assign in_map    = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0);
  assign req       = hsel & hready & htrans[1];
  assign hreadyout = ce & (ph_q == PH_IDLE);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // address phase capture; reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q    <= '0;
      ph_q     <= PH_IDLE;
      rd_idx_q <= 8'h00;
    end else if (ce) begin
      aph_q.wr  <= req & hwrite & in_map;
      aph_q.idx <= haddr[9:2];
      unique case (ph_q)
        PH_IDLE: begin
          if (req && !hwrite) begin
            ph_q     <= PH_RWAIT;
            rd_idx_q <= in_map ? haddr[9:2] : 8'h00;
          end
        end
        PH_RWAIT: begin
          ph_q <= PH_IDLE;
        end
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (rd_idx_q)
      IDX_CTRL:   rd_mux[7:0] = ctrl_q;                 // RULE14
      IDX_MODE:   rd_mux[1:0] = mode_q;
      IDX_CNT_LO: rd_mux[7:0] = count_low_byte_q;
      IDX_CNT_HI: rd_mux[7:0] = count_high_byte_q;
      IDX_RLD_LO: rd_mux[7:0] = reload_low_byte_q;
      IDX_RLD_HI: rd_mux[7:0] = reload_high_byte_q;
      IDX_IRQ_EN: rd_mux[IRQ_EN_BIT] = irq_en_q;
      IDX_STATUS: begin
        rd_mux[ST_DIR_BIT]             = direction_pin;
        rd_mux[ST_UPDN_BIT]            = updown;
        rd_mux[ST_MODE_LSB+1:ST_MODE_LSB] = mode;
        rd_mux[ST_IRQ_BIT]             = irq;
      end
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // read data loads during the wait cycle, after any prior write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ce && ph_q == PH_RWAIT) begin
      hrdata_q <= rd_mux;
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  chk_low_carry: assert property ( // RULE1
    @(posedge hclk) disable iff (!hresetn)
    (cnt_ev && up && count_low_byte_q == BYTE_TOP &&
     count != CNT_TOP && !aph_q.wr && !pin_trig)
    |=> count_high_byte_q == $past(count_high_byte_q) + 8'h01)
    else $error("low byte carry did not bump high byte");
  chk_run_hold: assert property ( // RULE3
    @(posedge hclk) disable iff (!hresetn)
    (!ctrl_q.run && !aph_q.wr && !pin_trig) |=> $stable(count))
    else $error("count moved while stopped");
  chk_src_select: assert property ( // RULE2
    @(posedge hclk) disable iff (!hresetn)
    (ce && ctrl_q.run && ctrl_q.ct) |-> (src_ev == pin_fall))
    else $error("counter mode not fed by count pin");
  chk_updown_mode: assert property ( // RULE5
    @(posedge hclk) disable iff (!hresetn)
    updown |-> (!serial && !ctrl_q.cprl && mode_q[MODE_DOWN_COUNT_ENABLE_BIT]))
    else $error("up/down active outside reload mode");
  chk_up_step: assert property ( // RULE6
    @(posedge hclk) disable iff (!hresetn)
    (cnt_ev && updown && direction_pin && count != CNT_TOP &&
     !aph_q.wr) |=> count == $past(count) + 16'h0001)
    else $error("up count step wrong");
  chk_up_reload: assert property ( // RULE8
    @(posedge hclk) disable iff (!hresetn)
    (wrap_up && mode != UDT_CAPTURE && !aph_q.wr)
    |=> count == $past(reload))
    else $error("overflow did not load reload value");
  chk_ovf_flag: assert property ( // RULE7
    @(posedge hclk) disable iff (!hresetn)
    (wrap_up && !serial) |=> ctrl_q.ovf ##0 (irq || !irq_en_q))
    else $error("overflow flag or request missing");
  chk_down_step: assert property ( // RULE9
    @(posedge hclk) disable iff (!hresetn)
    (cnt_ev && updown && !direction_pin && count != reload &&
     !aph_q.wr) |=> count == $past(count) - 16'h0001)
    else $error("down count step wrong");
  chk_count_underflow: assert property ( // RULE10
    @(posedge hclk) disable iff (!hresetn)
    (cnt_ev && updown && !direction_pin && count == reload &&
     !aph_q.wr) |=> (count == CNT_TOP) && ctrl_q.ovf)
    else $error("underflow not detected at reload value");
  chk_ext_toggle: assert property ( // RULE12
    @(posedge hclk) disable iff (!hresetn)
    ((wrap_up || wrap_dn) && updown && !aph_q.wr)
    |=> ctrl_q.ext != $past(ctrl_q.ext))
    else $error("external flag did not toggle on wrap");
  chk_ext_no_irq: assert property ( // RULE13
    @(posedge hclk) disable iff (!hresetn)
    (updown && !ctrl_q.ovf) |-> !irq)
    else $error("external flag raised request in up/down mode");
  chk_serial_noflag: assert property ( // RULE15
    @(posedge hclk) disable iff (!hresetn)
    (serial && ctrl_q.rclk == $past(ctrl_q.rclk) && !aph_q.wr &&
     !$past(aph_q.wr)) |-> $stable(ctrl_q.ovf))
    else $error("overflow flag set with serial clock select");
  chk_forced_reload: assert property ( // RULE17
    @(posedge hclk) disable iff (!hresetn)
    (wrap_up && serial && ctrl_q.cprl && !aph_q.wr)
    |=> count == $past(reload))
    else $error("serial select did not force reload");
  chk_irq_level: assert property ( // RULE19
    @(posedge hclk) disable iff (!hresetn)
    (irq_en_q && ctrl_q.ovf) |-> irq ##1 (ctrl_q.ovf || !irq ||
     ctrl_q.ext))
    else $error("request does not follow overflow flag");
  chk_read_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && req && !hwrite && hreadyout) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

endmodule // udt_timer

// *** verif/udt_pin_model.sv ***
`timescale 1ns/1ns
module udt_pin_model (
  input  wire logic hclk,            // bench clock
  output logic      count_input_pin, // count pin, idles high
  output logic      direction_pin    // direction level
);
  // ******
  // external pin side
  // ******
  // both lines start high, like a pulled-up pin
  initial begin
    count_input_pin = 1'b1;
    direction_pin   = 1'b1;
  end

  // n falling edges, low held gap cycles, high held gap plus one
  task automatic edges(input int n, input int gap);
    repeat (n) begin
      @(posedge hclk);
      count_input_pin <= 1'b0;
      repeat (gap) @(posedge hclk);
      count_input_pin <= 1'b1;
      repeat (gap) @(posedge hclk);
    end
  endtask

  // set the count direction level
  task automatic dir(input logic up);
    @(posedge hclk);
    direction_pin <= up;
  endtask
endmodule // udt_pin_model

// *** verif/udt_timer_bench.sv ***
`timescale 1ns/1ns
module udt_timer_bench import udt_pkg::*;;
  // ******
  // bench signals and instances
  // ******
  localparam int DV = 3;  // shortened divide ratio
  logic        hclk, hresetn, hwrite, hready, hresp, irq;
  logic        cpin, dpin, rd_pend, ce;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [31:0] expq[$];
  logic [15:0] r;
  int          fails, checks;

  // 10 MHz clock
  initial hclk = 1'b0;
  always #50 hclk = ~hclk;

  udt_timer #(.DIV(DV)) dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .count_input_pin(cpin),
    .direction_pin(dpin), .irq(irq));

  udt_pin_model pins (.hclk(hclk), .count_input_pin(cpin),
    .direction_pin(dpin));

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one single word transfer; a read notes its expected data
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    do @(negedge hclk); while (hready !== 1'b1);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    if (!wr) expq.push_back(d);
    rd_pend <= !wr;
    do @(negedge hclk); while (hready !== 1'b1);
    @(posedge hclk);
    rd_pend <= 1'b0;
  endtask

  // settled interrupt level
  task automatic irqc(input logic e);
    @(negedge hclk);
    chk({30'h0, hresp, irq}, {30'h0, 1'b0, e});
  endtask

  // verdict and end of run
  task automatic summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // take the oldest note when a read completes
  always @(negedge hclk)
    if (rd_pend && hready === 1'b1) chk(hrdata, expq.pop_front());

  // watchdog cuts a hang short
  initial begin
    #(100 * 20000);
    fails++;
    summarize();
  end

  // ******
  // test sequence
  // ******
  initial begin
    hresetn = 1'b0;
    htrans  = 2'h0;
    haddr   = 32'h0;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    rd_pend = 1'b0;
    ce      = 1'b1;
    fails   = 0;
    checks  = 0;
    void'($urandom(5367));
    r = 16'($urandom_range(16'hff00, 16'h0100));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++)
      bus(0, IDX_CTRL + 8'(i), 32'h0);
    bus(0, IDX_STATUS, 32'h5);
    bus(1, 8'hd0, 32'hff);
    bus(0, 8'hd0, 32'h0);
    $display("test reset done");
    bus(1, IDX_CNT_LO, 32'hfe);
    bus(1, IDX_CTRL, 32'h06);
    pins.edges(3, 1);
    bus(0, IDX_CNT_LO, 32'h01);
    bus(0, IDX_CNT_HI, 32'h01);
    bus(1, IDX_CTRL, 32'h02);
    pins.edges(2, 1);
    bus(0, IDX_CNT_LO, 32'h01);
    bus(1, IDX_CNT_LO, 32'h00);
    bus(1, IDX_CNT_HI, 32'h00);
    bus(1, IDX_CTRL, 32'h04);
    ce <= 1'b0;  // frozen cycles must not count
    repeat (7) @(posedge hclk);
    ce <= 1'b1;
    repeat (4 * DV - 2) @(posedge hclk);
    bus(1, IDX_CTRL, 32'h00);
    bus(0, IDX_CNT_LO, 32'h04);
    $display("test count sources done");
    bus(1, IDX_RLD_LO, {24'h0, r[7:0]});
    bus(1, IDX_RLD_HI, {24'h0, r[15:8]});
    bus(1, IDX_MODE, 32'h01);
    bus(1, IDX_CNT_LO, 32'hfe);
    bus(1, IDX_CNT_HI, 32'hff);
    bus(1, IDX_CTRL, 32'h06);
    pins.edges(2, 1 + $urandom_range(2));
    bus(0, IDX_CTRL, 32'hc6);
    bus(0, IDX_CNT_LO, {24'h0, r[7:0]});
    bus(0, IDX_CNT_HI, {24'h0, r[15:8]});
    irqc(1'b0);
    bus(1, IDX_IRQ_EN, 32'h01);
    irqc(1'b1);
    bus(0, IDX_STATUS, 32'h17);
    bus(1, IDX_CTRL, 32'h06);
    irqc(1'b0);
    pins.dir(1'b0);
    pins.edges(1, 1);
    bus(0, IDX_CTRL, 32'hc6);
    bus(0, IDX_CNT_HI, 32'hff);
    pins.edges(1, 1);
    bus(0, IDX_CNT_LO, 32'hfe);
    bus(1, IDX_CTRL, 32'h46);
    irqc(1'b0);
    bus(0, IDX_CTRL, 32'h46);
    $display("test up down done");
    bus(1, IDX_MODE, 32'h00);
    bus(1, IDX_CTRL, 32'h06);
    bus(1, IDX_CNT_LO, 32'hff);
    bus(1, IDX_CNT_HI, 32'hff);
    pins.edges(1, 1);
    bus(0, IDX_CTRL, 32'h86);
    bus(0, IDX_CNT_HI, {24'h0, r[15:8]});
    bus(1, IDX_CTRL, 32'h27);
    bus(1, IDX_CNT_LO, 32'hff);
    bus(1, IDX_CNT_HI, 32'hff);
    pins.edges(1, 1);
    bus(0, IDX_CTRL, 32'h27);
    bus(0, IDX_CNT_LO, {24'h0, r[7:0]});
    // direction pin fall with external enable reloads and sets the flag
    bus(1, IDX_CNT_HI, 32'h00);
    bus(1, IDX_CTRL, 32'h08);
    pins.dir(1'b1);
    pins.dir(1'b0);
    bus(0, IDX_CTRL, 32'h48);
    bus(0, IDX_CNT_HI, {24'h0, r[15:8]});
    irqc(1'b1);
    for (int i = 0; i < 3; i++) begin
      bus(1, IDX_CTRL, (i == 2) ? 32'h10 : 32'(i == 0));
      bus(0, IDX_STATUS, 32'(i) << 2);
    end
    $display("test modes done");
    summarize();
  end
endmodule // udt_timer_bench
